// ===== shared/cri_pkg.sv
package cri_pkg;

  // word indices; byte address is four times the index
  localparam logic [2:0] IDX_CONTROL     = 3'h0;
  localparam logic [2:0] IDX_MODE_STATUS = 3'h1;
  localparam logic [2:0] IDX_FLAGS       = 3'h4;
  localparam logic [2:0] IDX_ENABLES     = 3'h5;

  // control register fields
  localparam int BIT_INIT_REQ   = 0;
  localparam int BIT_WAKE_FN_EN = 2;
  // mode status register field
  localparam int BIT_INIT_ACK   = 0;

  // flag and enable register layout (shared)
  localparam int BIT_WAKE    = 7;
  localparam int BIT_CSC     = 6;
  localparam int BIT_RX_HI   = 5;
  localparam int BIT_RX_LO   = 4;
  localparam int BIT_TX_HI   = 3;
  localparam int BIT_TX_LO   = 2;
  localparam int BIT_OVERRUN = 1;
  localparam int BIT_RX_FULL = 0;

  // reset values
  localparam logic [7:0] RST_ENABLES = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'h00;

  // error counter thresholds
  localparam logic [8:0] LIM_WARN    = 9'h060;
  localparam logic [8:0] LIM_PASSIVE = 9'h07F;
  localparam logic [8:0] LIM_BUS_OFF = 9'h0FF;

  typedef enum logic [1:0] {
    ERR_OK      = 2'h0,
    ERR_WARN    = 2'h1,
    ERR_PASSIVE = 2'h2,
    ERR_BUS_OFF = 2'h3
  } cri_err_e;

  // sensitivity selections
  localparam logic [1:0] SENS_NONE    = 2'h0;
  localparam logic [1:0] SENS_BUS_OFF = 2'h1;
  localparam logic [1:0] SENS_PASSIVE = 2'h2;
  localparam logic [1:0] SENS_ALL     = 2'h3;

  typedef enum logic [1:0] {
    MODE_RUN      = 2'h0,
    MODE_ENTERING = 2'h1,
    MODE_INIT     = 2'h3,
    MODE_LEAVING  = 2'h2
  } cri_mode_e;

  typedef struct packed {
    logic wake;
    logic overrun;
    logic rx_full;
  } cri_evt_s;

  typedef struct packed {
    logic [8:0] tx_count;
    logic [7:0] rx_count;
  } cri_cnt_s;

  typedef struct packed {
    logic wake;
    logic error;
    logic receive;
  } cri_irq_s;

endpackage

// ===== rtl/cri_state_enc.sv
`timescale 1ns/100ps
`default_nettype none
// maps an error counter onto the four-level bus state
module cri_state_enc (
  input  wire logic [8:0]      count,
  input  wire logic            bus_off,
  output cri_pkg::cri_err_e    state
);

  always_comb begin
    if (bus_off) begin
      state = cri_pkg::ERR_BUS_OFF;
    end else if (count <= cri_pkg::LIM_WARN) begin
      state = cri_pkg::ERR_OK;
    end else if (count <= cri_pkg::LIM_PASSIVE) begin
      state = cri_pkg::ERR_WARN;
    end else begin
      state = cri_pkg::ERR_PASSIVE;
    end
  end

endmodule // cri_state_enc
`default_nettype wire

// ===== rtl/cri_receive_irq_enable.sv
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - init mode holds enables at reset value
// - read anytime, write only outside init
// - sensitivity fields survive init mode
// - wake enable gates wake request
// - status-change enable gates error request
// - receiver sensitivity selects counted transitions
// - transmitter sensitivity selects counted transitions
// - reported states update only without pending flag
// - overrun enable gates error request
// - receive-full enable gates receiver request
// - transmitter leaving bus-off forces receiver OK
// - error state change selected by a sensitivity field sets status-change flag
// - receiver state encoding from counters
// - transmitter state encoding from counters
module cri_receive_irq_enable (
  input  wire logic               mclk,
  input  wire logic               rst_n,
  input  wire logic [4:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  input  wire logic [3:0]         avs_byteenable,
  output logic [31:0]             avs_readdata,
  output logic                    avs_waitrequest,
  input  wire cri_pkg::cri_evt_s  events,
  input  wire cri_pkg::cri_cnt_s  counters,
  output cri_pkg::cri_irq_s       irq_lines,
  output logic                    irq,
  output logic                    init_mode_acknowledge,
  output logic                    wake_function_enable
);

  typedef struct packed {
    logic               busy;
    logic [31:0]        rdata;
    logic               init_mode_request;
    logic               wake_fn_en;
    cri_pkg::cri_mode_e mode;
    logic               wake_irq_enable;
    logic               status_change_irq_enable;
    logic [1:0]         receiver_sensitivity;
    logic [1:0]         transmitter_sensitivity;
    logic               overrun_irq_enable;
    logic               receive_full_irq_enable;
    logic               wake_flag;
    logic               status_change_flag;
    logic               overrun_flag;
    logic               receive_full_flag;
    cri_pkg::cri_err_e  receiver_state;
    cri_pkg::cri_err_e  transmitter_state;
    cri_pkg::cri_err_e  prev_rx;
    cri_pkg::cri_err_e  prev_tx;
  } cri_regs_s;

  cri_regs_s         s;
  cri_regs_s         next_s;
  cri_pkg::cri_err_e rx_enc;
  cri_pkg::cri_err_e tx_enc;
  logic              tx_bus_off;
  localparam logic [7:0] RST_EN = cri_pkg::RST_ENABLES;

  // receiver bus-off follows the transmit counter, not its own
  assign tx_bus_off = counters.tx_count > cri_pkg::LIM_BUS_OFF;

  cri_state_enc u_rx_enc (
    .count   ({1'b0, counters.rx_count}),
    .bus_off (tx_bus_off),
    .state   (rx_enc)
  );

  cri_state_enc u_tx_enc (
    .count   (counters.tx_count),
    .bus_off (tx_bus_off),
    .state   (tx_enc)
  );

  // true when a transition a->b is one the selection wants reported
  function automatic logic sens_hit(
    input logic [1:0]        sel,
    input cri_pkg::cri_err_e a,
    input cri_pkg::cri_err_e b
  );
    logic hit;
    hit = 1'b0;
    case (sel)
      cri_pkg::SENS_NONE: begin
        hit = 1'b0;
      end
      cri_pkg::SENS_BUS_OFF: begin
        hit = (a == cri_pkg::ERR_BUS_OFF) != (b == cri_pkg::ERR_BUS_OFF);
      end
      cri_pkg::SENS_PASSIVE: begin
        // passive and bus-off share the upper code bit
        hit = a[1] != b[1];
      end
      cri_pkg::SENS_ALL: begin
        hit = a != b;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction

  logic              req;
  logic              writable;
  logic              wr_now;
  logic              rd_first;
  logic [2:0]        idx;
  logic              word_ok;
  logic              lane0_wr;
  logic [7:0]        wbyte;
  logic [7:0]        flags_rd;
  logic [7:0]        enables_rd;
  cri_pkg::cri_err_e rx_now;
  logic              state_hit;
  logic              clr_wake;
  logic              clr_csc;
  logic              clr_ovr;
  logic              clr_rxf;

  assign req      = avs_read | avs_write;
  assign idx      = avs_address[4:2];
  assign word_ok  = avs_address[1:0] == 2'h0;
  assign writable = ~s.init_mode_request & (s.mode != cri_pkg::MODE_INIT);
  // a write acts only on the edge after its wait state, once waitrequest is low
  assign wr_now   = avs_write & s.busy & word_ok;
  assign rd_first = avs_read & ~s.busy;
  assign lane0_wr = wr_now & avs_byteenable[0];
  assign wbyte    = avs_writedata[7:0];

  // reported states, so software reads a frozen snapshot while flagged
  assign flags_rd = {s.wake_flag, s.status_change_flag,
                     s.receiver_state, s.transmitter_state,
                     s.overrun_flag, s.receive_full_flag};

  assign enables_rd = {s.wake_irq_enable, s.status_change_irq_enable,
                       s.receiver_sensitivity, s.transmitter_sensitivity,
                       s.overrun_irq_enable, s.receive_full_irq_enable};

  // bus-off exit of the transmitter drags the receiver straight to OK
  assign rx_now = (s.prev_tx == cri_pkg::ERR_BUS_OFF && tx_enc != cri_pkg::ERR_BUS_OFF)
                  ? cri_pkg::ERR_OK : rx_enc;

  // compared against last cycle's encoding, not the reported one
  assign state_hit = sens_hit(s.receiver_sensitivity, s.prev_rx, rx_now)
                   | sens_hit(s.transmitter_sensitivity, s.prev_tx, tx_enc);

  assign clr_wake = lane0_wr & (idx == cri_pkg::IDX_FLAGS) & wbyte[cri_pkg::BIT_WAKE];
  assign clr_csc  = lane0_wr & (idx == cri_pkg::IDX_FLAGS) & wbyte[cri_pkg::BIT_CSC];
  assign clr_ovr  = lane0_wr & (idx == cri_pkg::IDX_FLAGS) & wbyte[cri_pkg::BIT_OVERRUN];
  assign clr_rxf  = lane0_wr & (idx == cri_pkg::IDX_FLAGS) & wbyte[cri_pkg::BIT_RX_FULL];

  always_comb begin
    next_s = s;

    // one wait state per access; write lands on the released edge
    next_s.busy = req & ~s.busy;
    if (rd_first) begin
      next_s.rdata = 32'h0000_0000;
      if (word_ok) begin
        case (idx)
          cri_pkg::IDX_CONTROL: begin
            next_s.rdata[cri_pkg::BIT_INIT_REQ]   = s.init_mode_request;
            next_s.rdata[cri_pkg::BIT_WAKE_FN_EN] = s.wake_fn_en;
          end
          cri_pkg::IDX_MODE_STATUS: begin
            next_s.rdata[cri_pkg::BIT_INIT_ACK] = s.mode == cri_pkg::MODE_INIT;
          end
          cri_pkg::IDX_FLAGS: begin
            next_s.rdata[7:0] = flags_rd;
          end
          cri_pkg::IDX_ENABLES: begin
            next_s.rdata[7:0] = enables_rd;
          end
          default: begin
            next_s.rdata = 32'h0000_0000;
          end
        endcase
      end
    end

    if (lane0_wr && idx == cri_pkg::IDX_CONTROL) begin
      next_s.init_mode_request = wbyte[cri_pkg::BIT_INIT_REQ];
      next_s.wake_fn_en        = wbyte[cri_pkg::BIT_WAKE_FN_EN];
    end

    // acknowledge follows the request through a short handshake
    case (s.mode)
      cri_pkg::MODE_RUN: begin
        if (s.init_mode_request) begin
          next_s.mode = cri_pkg::MODE_ENTERING;
        end
      end
      cri_pkg::MODE_ENTERING: begin
        next_s.mode = cri_pkg::MODE_INIT;
      end
      cri_pkg::MODE_INIT: begin
        if (!s.init_mode_request) begin
          next_s.mode = cri_pkg::MODE_LEAVING;
        end
      end
      cri_pkg::MODE_LEAVING: begin
        next_s.mode = cri_pkg::MODE_RUN;
      end
      default: begin
        next_s.mode = cri_pkg::MODE_RUN;
      end
    endcase

    if (lane0_wr && idx == cri_pkg::IDX_ENABLES && writable) begin
      next_s.wake_irq_enable          = wbyte[cri_pkg::BIT_WAKE];
      next_s.status_change_irq_enable = wbyte[cri_pkg::BIT_CSC];
      next_s.receiver_sensitivity     = wbyte[cri_pkg::BIT_RX_HI:cri_pkg::BIT_RX_LO];
      next_s.transmitter_sensitivity  = wbyte[cri_pkg::BIT_TX_HI:cri_pkg::BIT_TX_LO];
      next_s.overrun_irq_enable       = wbyte[cri_pkg::BIT_OVERRUN];
      next_s.receive_full_irq_enable  = wbyte[cri_pkg::BIT_RX_FULL];
    end
    // sensitivity fields are left alone here on purpose
    // forced from the edge that raises acknowledge, so no stale cycle shows
    if (next_s.init_mode_request && (next_s.mode == cri_pkg::MODE_INIT)) begin
      next_s.wake_irq_enable          = RST_EN[cri_pkg::BIT_WAKE];
      next_s.status_change_irq_enable = RST_EN[cri_pkg::BIT_CSC];
      next_s.overrun_irq_enable       = RST_EN[cri_pkg::BIT_OVERRUN];
      next_s.receive_full_irq_enable  = RST_EN[cri_pkg::BIT_RX_FULL];
    end

    // set beats clear in the same cycle
    if (events.wake && s.wake_fn_en) begin
      next_s.wake_flag = 1'b1;
    end else if (clr_wake) begin
      next_s.wake_flag = 1'b0;
    end
    if (events.overrun) begin
      next_s.overrun_flag = 1'b1;
    end else if (clr_ovr) begin
      next_s.overrun_flag = 1'b0;
    end
    if (events.rx_full) begin
      next_s.receive_full_flag = 1'b1;
    end else if (clr_rxf) begin
      next_s.receive_full_flag = 1'b0;
    end
    if (state_hit) begin
      next_s.status_change_flag = 1'b1;
    end else if (clr_csc) begin
      next_s.status_change_flag = 1'b0;
    end

    next_s.prev_rx = rx_now;
    next_s.prev_tx = tx_enc;
    // a pending flag freezes what software sees
    if (!s.status_change_flag) begin
      next_s.receiver_state    = rx_now;
      next_s.transmitter_state = tx_enc;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s                          <= '0;
      s.mode                     <= cri_pkg::MODE_RUN;
      s.init_mode_request        <= cri_pkg::RST_CONTROL[cri_pkg::BIT_INIT_REQ];
      s.wake_fn_en               <= cri_pkg::RST_CONTROL[cri_pkg::BIT_WAKE_FN_EN];
      s.wake_irq_enable          <= RST_EN[cri_pkg::BIT_WAKE];
      s.status_change_irq_enable <= RST_EN[cri_pkg::BIT_CSC];
      s.receiver_sensitivity     <= RST_EN[cri_pkg::BIT_RX_HI:cri_pkg::BIT_RX_LO];
      s.transmitter_sensitivity  <= RST_EN[cri_pkg::BIT_TX_HI:cri_pkg::BIT_TX_LO];
      s.overrun_irq_enable       <= RST_EN[cri_pkg::BIT_OVERRUN];
      s.receive_full_irq_enable  <= RST_EN[cri_pkg::BIT_RX_FULL];
      s.receiver_state           <= cri_pkg::ERR_OK;
      s.transmitter_state        <= cri_pkg::ERR_OK;
      s.prev_rx                  <= cri_pkg::ERR_OK;
      s.prev_tx                  <= cri_pkg::ERR_OK;
    end else begin
      s <= next_s;
    end
  end

  assign avs_readdata    = s.rdata;
  assign avs_waitrequest = req & ~s.busy;

  // request lines only gate registered flags with registered enables
  always_comb begin
    irq_lines.wake    = s.wake_flag & s.wake_irq_enable;
    irq_lines.error   = (s.status_change_flag & s.status_change_irq_enable)
                      | (s.overrun_flag & s.overrun_irq_enable);
    irq_lines.receive = s.receive_full_flag & s.receive_full_irq_enable;
  end
  assign irq = irq_lines.wake | irq_lines.error | irq_lines.receive;

  // the wake enable alone does not arm wake-up; the control bit must too
  assign wake_function_enable  = s.wake_fn_en;
  assign init_mode_acknowledge = s.mode == cri_pkg::MODE_INIT;

endmodule // cri_receive_irq_enable
`default_nettype wire

// ===== verification/cri_receive_irq_enable_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module cri_receive_irq_enable_assertions (
  input wire logic              mclk,
  input wire logic              rst_n,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [31:0]       avs_readdata,
  input wire logic              avs_waitrequest,
  input wire cri_pkg::cri_evt_s events,
  input wire cri_pkg::cri_cnt_s counters,
  input wire cri_pkg::cri_irq_s irq_lines,
  input wire logic              irq,
  input wire logic              init_mode_acknowledge
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence req_wait;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence

  // flags settle one edge after their cause, so four calm cycles leave margin
  sequence quiet;
    (!avs_write && events == 3'h0 && $stable(counters)) [*4];
  endsequence

  irq_or_a: assert property (irq == (|irq_lines))
    else $error("irq differs from OR of lines");
  wait_first_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("no wait on first access cycle");
  wait_one_a: assert property (req_wait |=> !avs_waitrequest)
    else $error("access not answered after one wait");
  idle_nowait_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("wait raised while idle");
  data_upper_a: assert property (avs_readdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
  data_hold_a: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("read data moved outside a read capture");
  init_quiet_a: assert property (init_mode_acknowledge [*2] |-> !irq)
    else $error("interrupt during init mode");
  irq_steady_a: assert property (quiet |-> $stable(irq_lines))
    else $error("request lines moved without cause");
endmodule // cri_receive_irq_enable_assertions
bind cri_receive_irq_enable cri_receive_irq_enable_assertions chk (
  .mclk(mclk), .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .events(events),
  .counters(counters), .irq_lines(irq_lines), .irq(irq),
  .init_mode_acknowledge(init_mode_acknowledge));
`default_nettype wire

// ===== verification/cri_can_node.sv
`timescale 1ns/100ps
`default_nettype none
// stands for the bus side: receive events and error counters
module cri_can_node (
  input  wire logic         mclk,
  output cri_pkg::cri_evt_s events,
  output cri_pkg::cri_cnt_s counters
);
  initial begin
    events = 3'h0;
    counters = 17'h00000;
  end
  // events last one cycle only, as the receive path gives them
  task automatic pulse(input int k);
    @(posedge mclk);
    events[k] <= 1'b1;
    @(posedge mclk);
    events <= 3'h0;
  endtask
  task automatic set_counts(input logic [8:0] tx, input logic [7:0] rx);
    @(posedge mclk);
    counters <= {tx, rx};
  endtask
endmodule // cri_can_node
`default_nettype wire

// ===== verification/cri_receive_irq_enable_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module cri_receive_irq_enable_tb_top;
  logic              mclk;
  logic              rst_n;
  logic [4:0]        avs_address;
  logic              avs_read;
  logic              avs_write;
  logic [31:0]       avs_writedata;
  logic [3:0]        avs_byteenable;
  logic [3:0]        be_mask;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  cri_pkg::cri_evt_s events;
  cri_pkg::cri_cnt_s counters;
  cri_pkg::cri_irq_s irq_lines;
  logic              irq;
  logic              ack;
  logic              wake_fn;
  int                fail_count;
  int                cmp_count;
  logic [7:0]        rd;
  logic [7:0]        en [3] = '{8'h80, 8'h02, 8'h01};

  cri_can_node node (.mclk(mclk), .events(events), .counters(counters));
  cri_receive_irq_enable dut (
    .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .events(events),
    .counters(counters), .irq_lines(irq_lines), .irq(irq),
    .init_mode_acknowledge(ack), .wake_function_enable(wake_fn));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // holds the request until the slave drops its wait
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_byteenable <= be_mask;
    avs_read <= ~wr;
    avs_write <= wr;
    // wait state and read data are sampled at the same rising edge
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wait_ack(input logic v);
    int n;
    n = 0;
    while (ack !== v && n < 20) begin
      @(negedge mclk);
      n++;
    end
    cmp8({7'h00, ack}, {7'h00, v});
  endtask

  task automatic cnt(input logic [8:0] tx, input logic [7:0] rx);
    node.set_counts(tx, rx);
    repeat (3) @(negedge mclk);
    bus(1'b0, 5'h10, 8'h00);
  endtask

  initial begin
    rst_n = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hF;
    be_mask = 4'hF;
    fail_count = 0;
    cmp_count = 0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    bus(1'b0, 5'h14, 8'h00);
    cmp8(rd, cri_pkg::RST_ENABLES);
    bus(1'b0, 5'h1C, 8'h00);
    cmp8(rd, 8'h00);
    bus(1'b1, 5'h14, 8'hFF);
    bus(1'b0, 5'h14, 8'h00);
    cmp8(rd, 8'hFF);
    be_mask = 4'hE;
    bus(1'b1, 5'h14, 8'h00);
    be_mask = 4'hF;
    bus(1'b0, 5'h14, 8'h00);
    cmp8(rd, 8'hFF);
    bus(1'b1, 5'h00, 8'h05);
    wait_ack(1'b1);
    cmp8({7'h00, wake_fn}, 8'h01);
    bus(1'b0, 5'h04, 8'h00);
    cmp8(rd, 8'h01);
    bus(1'b0, 5'h14, 8'h00);
    cmp8(rd, 8'h3C);
    bus(1'b1, 5'h14, 8'h00);
    bus(1'b0, 5'h14, 8'h00);
    cmp8(rd, 8'h3C);
    bus(1'b1, 5'h00, 8'h04);
    wait_ack(1'b0);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, 5'h14, 8'h00);
      node.pulse(2 - i);
      repeat (3) @(negedge mclk);
      cmp8({5'h00, irq_lines}, 8'h00);
      bus(1'b1, 5'h14, en[i]);
      repeat (2) @(negedge mclk);
      cmp8({5'h00, irq_lines}, 8'h04 >> i);
      cmp8({7'h00, irq}, 8'h01);
      bus(1'b1, 5'h10, 8'hC3);
    end
    bus(1'b1, 5'h14, 8'h44);
    cnt(9'h070, 8'h00);
    cmp8(rd, 8'h04);
    cmp8({7'h00, irq}, 8'h00);
    cnt(9'h100, 8'h00);
    cmp8(rd, 8'h7C);
    cmp8({5'h00, irq_lines}, 8'h02);
    cnt(9'h000, 8'h00);
    cmp8(rd, 8'h7C);
    bus(1'b1, 5'h10, 8'h40);
    bus(1'b0, 5'h10, 8'h00);
    cmp8(rd & 8'h3C, 8'h00);
    bus(1'b1, 5'h10, 8'h40);
    bus(1'b1, 5'h14, 8'h60);
    cnt(9'h000, 8'h70);
    cmp8(rd, 8'h10);
    cnt(9'h000, 8'h80);
    cmp8(rd, 8'h60);
    cmp8({7'h00, irq}, 8'h01);
    bus(1'b1, 5'h14, 8'h20);
    bus(1'b1, 5'h10, 8'h40);
    cnt(9'h000, 8'h00);
    cmp8(rd, 8'h40);
    cmp8({7'h00, irq}, 8'h00);
    bus(1'b1, 5'h00, 8'h00);
    bus(1'b1, 5'h14, 8'h80);
    node.pulse(2);
    repeat (3) @(negedge mclk);
    cmp8({5'h00, irq_lines}, 8'h00);
    cmp8({7'h00, wake_fn}, 8'h00);
    bus(1'b0, 5'h10, 8'h00);
    cmp8(rd, 8'h40);
    end_of_test();
  end

  initial begin
    repeat (5000) @(posedge mclk);
    fail_count++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    end_of_test();
  end
endmodule // cri_receive_irq_enable_tb_top
`default_nettype wire
